// *** src/link_mirror_pkg.sv ***
package link_mirror_pkg;
    // ========================================================
    // shared area geometry
    localparam int WORD_W = 16;
    localparam int AREA_WORDS = 64;
    localparam int IDX_W = 6;
    localparam int HALF_W = 7;
    // ========================================================
    // port mode setting word fields
    localparam int ROLE_LSB = 12;
    localparam int SIZE_LSB = 8;
    localparam logic [3:0] ROLE_SLAVE = 4'h2;
    localparam logic [3:0] ROLE_MASTER = 4'h3;
    localparam logic [3:0] SIZE_CODE_64 = 4'h0;
    localparam logic [3:0] SIZE_CODE_32 = 4'h1;
    localparam logic [3:0] SIZE_CODE_16 = 4'h2;
    // ========================================================
    // owned half sizes, i.e. first slave word
    localparam logic [6:0] HALF_OF_64 = 7'h20;
    localparam logic [6:0] HALF_OF_32 = 7'h10;
    localparam logic [6:0] HALF_OF_16 = 7'h08;
    localparam logic [6:0] HALF_UNKNOWN = 7'h00;
    localparam logic [6:0] HALF_MAX = 7'h20;
    // ========================================================
    // reset values
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [5:0] IDX_RESET = 6'h00;
endpackage : link_mirror_pkg

// *** src/word_cell.sv ***
`timescale 1ns/1ps
`default_nettype none
module word_cell #(
    parameter int W = 16
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic wrEn,
    input wire logic [W-1:0] wrData,
    output logic [W-1:0] q_reg
);
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            q_reg <= '0;
        end else if (wrEn) begin
            q_reg <= wrData;
        end
    end
endmodule : word_cell
`default_nettype wire

// *** src/paired_link_area_mirror.sv ***
`timescale 1ns/1ps
`default_nettype none
module paired_link_area_mirror (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [15:0] portModeSettingWord,
    input wire logic hostWrEn,
    input wire logic [link_mirror_pkg::IDX_W-1:0] hostWrIdx,
    input wire logic [link_mirror_pkg::WORD_W-1:0] hostWrData,
    input wire logic [link_mirror_pkg::IDX_W-1:0] hostRdIdx,
    output logic [link_mirror_pkg::WORD_W-1:0] hostRdData_reg,
    output logic hostWrRefused_reg,
    output logic linkTxValid_reg,
    input wire logic linkTxReady,
    output logic [link_mirror_pkg::IDX_W-1:0] linkTxIdx_reg,
    output logic [link_mirror_pkg::WORD_W-1:0] linkTxData_reg,
    output logic linkTxLast_reg,
    input wire logic linkRxValid,
    input wire logic [link_mirror_pkg::IDX_W-1:0] linkRxIdx,
    input wire logic [link_mirror_pkg::WORD_W-1:0] linkRxData,
    input wire logic linkRxLast,
    output logic isMaster_reg,
    output logic linkActive_reg,
    output logic configFault_reg
);
    import link_mirror_pkg::*;

    typedef enum logic [1:0] {ST_CFG, ST_TX, ST_RX, ST_FAULT} link_state_e;

    link_state_e stateReg;
    logic [HALF_W-1:0] halfReg;
    logic [HALF_W-1:0] txCntReg;
    logic [WORD_W-1:0] cellQ [AREA_WORDS];
    logic [3:0] roleCode;
    logic [3:0] sizeCode;
    logic [HALF_W-1:0] cfgHalf;
    logic cfgMaster;
    logic cfgSlave;
    logic [HALF_W-1:0] areaEnd;
    logic [IDX_W-1:0] ownBase;
    logic [HALF_W-1:0] rxBound;
    logic hostWrOk;
    logic rxOk;
    logic txFire;
    logic txFinal;
    logic [IDX_W-1:0] txIdxNext;

    // ========================================================
    // mode decode
    assign roleCode = portModeSettingWord[ROLE_LSB +: 4];
    assign sizeCode = portModeSettingWord[SIZE_LSB +: 4];
    assign cfgMaster = (roleCode == ROLE_MASTER);
    assign cfgSlave = (roleCode == ROLE_SLAVE);

    always_comb begin
        unique case (sizeCode)
            SIZE_CODE_64: cfgHalf = HALF_OF_64;
            SIZE_CODE_32: cfgHalf = HALF_OF_32;
            SIZE_CODE_16: cfgHalf = HALF_OF_16;
            default: cfgHalf = HALF_UNKNOWN;
        endcase
    end

    // ========================================================
    // ownership of words
    assign areaEnd = {halfReg[HALF_W-2:0], 1'b0};
    assign ownBase = isMaster_reg ? IDX_RESET : halfReg[IDX_W-1:0];
    // slave learns the split only at the end of the first master frame
    assign rxBound = (halfReg == HALF_UNKNOWN) ? HALF_MAX : halfReg;

    always_comb begin
        hostWrOk = 1'b0;
        if (hostWrEn && (stateReg == ST_TX || stateReg == ST_RX)) begin
            if (isMaster_reg) begin
                hostWrOk = ({1'b0, hostWrIdx} < halfReg);
            end else begin
                hostWrOk = ({1'b0, hostWrIdx} >= halfReg) && ({1'b0, hostWrIdx} < areaEnd)
                    && (halfReg != HALF_UNKNOWN);
            end
        end
    end

    always_comb begin
        rxOk = 1'b0;
        if (linkRxValid && (stateReg == ST_RX || stateReg == ST_TX)) begin
            if (isMaster_reg) begin
                rxOk = ({1'b0, linkRxIdx} >= halfReg) && ({1'b0, linkRxIdx} < areaEnd);
            end else begin
                rxOk = ({1'b0, linkRxIdx} < rxBound);
            end
        end
    end

    // ========================================================
    // word storage
    genvar gi;
    generate
        for (gi = 0; gi < AREA_WORDS; gi++) begin : g_cell
            logic hostHit;
            logic rxHit;
            assign hostHit = hostWrOk && (hostWrIdx == IDX_W'(gi));
            assign rxHit = rxOk && (linkRxIdx == IDX_W'(gi));
            word_cell #(.W(WORD_W)) u_cell (
                .clk_sys(clk_sys),
                .arst_n(arst_n),
                .wrEn(hostHit || rxHit),
                .wrData(hostHit ? hostWrData : linkRxData),
                .q_reg(cellQ[gi])
            );
        end
    endgenerate

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            hostRdData_reg <= WORD_RESET;
            hostWrRefused_reg <= 1'b0;
        end else begin
            hostRdData_reg <= cellQ[hostRdIdx];
            hostWrRefused_reg <= hostWrEn && !hostWrOk;
        end
    end

    // ========================================================
    // link sequencing
    assign txFire = linkTxValid_reg && linkTxReady;
    assign txFinal = (txCntReg == halfReg - 7'h01);
    assign txIdxNext = linkTxIdx_reg + 6'h01;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            stateReg <= ST_CFG;
            isMaster_reg <= 1'b0;
            halfReg <= HALF_UNKNOWN;
            linkActive_reg <= 1'b0;
            configFault_reg <= 1'b0;
            txCntReg <= HALF_UNKNOWN;
            linkTxValid_reg <= 1'b0;
            linkTxIdx_reg <= IDX_RESET;
            linkTxData_reg <= WORD_RESET;
            linkTxLast_reg <= 1'b0;
        end else begin
            unique case (stateReg)
                ST_CFG: begin
                    if (cfgMaster && cfgHalf != HALF_UNKNOWN) begin
                        isMaster_reg <= 1'b1;
                        halfReg <= cfgHalf;
                        linkActive_reg <= 1'b1;
                        stateReg <= ST_TX;
                        txCntReg <= HALF_UNKNOWN;
                        linkTxValid_reg <= 1'b1;
                        linkTxIdx_reg <= IDX_RESET;
                        linkTxData_reg <= cellQ[0];
                        linkTxLast_reg <= (cfgHalf == 7'h01);
                    end else if (cfgSlave) begin
                        halfReg <= HALF_UNKNOWN;
                        linkActive_reg <= 1'b1;
                        stateReg <= ST_RX;
                    end else begin
                        configFault_reg <= 1'b1;
                        stateReg <= ST_FAULT;
                    end
                end
                ST_TX: begin
                    if (txFire) begin
                        if (txFinal) begin
                            linkTxValid_reg <= 1'b0;
                            linkTxLast_reg <= 1'b0;
                            stateReg <= ST_RX;
                        end else begin
                            txCntReg <= txCntReg + 7'h01;
                            linkTxIdx_reg <= txIdxNext;
                            linkTxData_reg <= cellQ[txIdxNext];
                            linkTxLast_reg <= (txCntReg + 7'h02 == halfReg);
                        end
                    end
                end
                ST_RX: begin
                    if (linkRxValid && linkRxLast) begin
                        if (!isMaster_reg && halfReg == HALF_UNKNOWN) begin
                            // the master's frame length fixes the split
                            halfReg <= {1'b0, linkRxIdx} + 7'h01;
                            linkTxIdx_reg <= linkRxIdx + 6'h01;
                            linkTxData_reg <= cellQ[linkRxIdx + 6'h01];
                            linkTxLast_reg <= (linkRxIdx == IDX_RESET);
                        end else begin
                            linkTxIdx_reg <= ownBase;
                            linkTxData_reg <= cellQ[ownBase];
                            linkTxLast_reg <= (halfReg == 7'h01);
                        end
                        txCntReg <= HALF_UNKNOWN;
                        linkTxValid_reg <= 1'b1;
                        stateReg <= ST_TX;
                    end
                end
                ST_FAULT: begin
                    stateReg <= ST_FAULT;
                end
            endcase
        end
    end

    // ========================================================
    // checks
    refused_write_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        hostWrEn && !hostWrOk |=> hostWrRefused_reg)
        else $error("write to foreign word not refused");

    own_write_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        hostWrOk |=> cellQ[$past(hostWrIdx)] == $past(hostWrData))
        else $error("own word write lost");

    mirror_store_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        rxOk && !hostWrOk |=> cellQ[$past(linkRxIdx)] == $past(linkRxData))
        else $error("partner word not mirrored");

    master_half_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        linkTxValid_reg && isMaster_reg |-> {1'b0, linkTxIdx_reg} < halfReg)
        else $error("master sent a word outside its half");

    slave_half_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        linkTxValid_reg && !isMaster_reg |->
            {1'b0, linkTxIdx_reg} >= halfReg && {1'b0, linkTxIdx_reg} < areaEnd)
        else $error("slave sent a word outside its half");

    master_cfg_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        stateReg == ST_CFG && portModeSettingWord == 16'h3200 |=>
            isMaster_reg && halfReg == 7'h08 && linkTxValid_reg ##1 linkActive_reg)
        else $error("master setting not applied");

    slave_cfg_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        stateReg == ST_CFG && portModeSettingWord == 16'h2000 |=>
            !isMaster_reg && stateReg == ST_RX && !linkTxValid_reg)
        else $error("slave setting not applied");

    slave_size_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        stateReg == ST_CFG && cfgSlave |=> halfReg == HALF_UNKNOWN)
        else $error("slave took the size field");

    auto_start_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        stateReg == ST_CFG && (cfgSlave || (cfgMaster && cfgHalf != HALF_UNKNOWN))
            |=> linkActive_reg && !configFault_reg)
        else $error("link did not start by itself");

    bad_role_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        stateReg == ST_CFG && !cfgSlave && !cfgMaster |=> configFault_reg && !linkActive_reg)
        else $error("invalid role not flagged");

    turn_over_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        txFire && linkTxLast_reg |=> !linkTxValid_reg && stateReg == ST_RX)
        else $error("send turn not handed over");
endmodule : paired_link_area_mirror
`default_nettype wire

// *** tb/far_end_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module far_end_model (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic lead,
    input wire logic slow,
    input wire logic txValid,
    input wire logic [5:0] txIdx,
    input wire logic [15:0] txData,
    input wire logic txLast,
    output logic txReady,
    output logic rxValid,
    output logic [5:0] rxIdx,
    output logic [15:0] rxData,
    output logic rxLast
);
    logic [15:0] seen [64];
    logic [6:0] cnt;
    logic [6:0] endIdx;
    logic sending;
    logic started;
    // ====
    // lead plays master, otherwise slave answering the block's frame
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            txReady <= 1'h0;
            rxValid <= 1'h0;
            rxLast <= 1'h0;
            rxIdx <= 6'h00;
            rxData <= 16'h0000;
            sending <= 1'h0;
            started <= 1'h0;
            cnt <= 7'h00;
            endIdx <= 7'h00;
        end else begin
            txReady <= slow ? ~txReady : 1'h1;
            if (lead && !started) begin
                started <= 1'h1;
                sending <= 1'h1;
                cnt <= 7'h00;
                endIdx <= 7'h07;
            end
            if (txValid && txReady) begin
                seen[txIdx] <= txData;
                if (txLast) begin
                    sending <= 1'h1;
                    cnt <= lead ? 7'h00 : 7'(txIdx) + 7'h01;
                    endIdx <= lead ? 7'h07 : 7'(txIdx) * 7'h02 + 7'h01;
                end
            end
            if (sending) begin
                rxValid <= 1'h1;
                rxIdx <= cnt[5:0];
                rxData <= 16'hA000 | 16'(cnt);
                rxLast <= (cnt == endIdx);
                cnt <= cnt + 7'h01;
                sending <= (cnt != endIdx);
            end else begin
                // released lines do not keep the last value
                rxValid <= 1'h0;
                rxLast <= 1'h0;
                rxIdx <= ~rxIdx;
                rxData <= ~rxData;
            end
        end
    end
endmodule : far_end_model
`default_nettype wire

// *** tb/paired_link_area_mirror_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module paired_link_area_mirror_tb_top;
    logic clk_sys = 1'h0;
    logic arst_n = 1'h0;
    logic [15:0] portModeSettingWord = 16'h0000;
    logic lead = 1'h0;
    logic slow = 1'h0;
    logic hostWrEn = 1'h0;
    logic [5:0] hostWrIdx = 6'h00;
    logic [15:0] hostWrData = 16'h0000;
    logic [5:0] hostRdIdx = 6'h00;
    logic [15:0] hostRdData_reg;
    logic hostWrRefused_reg, linkTxValid_reg, linkTxReady, linkTxLast_reg;
    logic linkRxValid, linkRxLast, isMaster_reg, linkActive_reg, configFault_reg;
    logic [5:0] linkTxIdx_reg, linkRxIdx;
    logic [15:0] linkTxData_reg, linkRxData;
    int nFail = 0;
    int totalChecks = 0;
    always #2.5 clk_sys = ~clk_sys;
    paired_link_area_mirror u_paired_link_area_mirror (
        .clk_sys, .arst_n, .portModeSettingWord, .hostWrEn, .hostWrIdx, .hostWrData,
        .hostRdIdx, .hostRdData_reg, .hostWrRefused_reg, .linkTxValid_reg, .linkTxReady,
        .linkTxIdx_reg, .linkTxData_reg, .linkTxLast_reg, .linkRxValid, .linkRxIdx,
        .linkRxData, .linkRxLast, .isMaster_reg, .linkActive_reg, .configFault_reg
    );
    far_end_model u_far_end_model (
        .clk_sys, .arst_n, .lead, .slow, .txValid(linkTxValid_reg), .txIdx(linkTxIdx_reg),
        .txData(linkTxData_reg), .txLast(linkTxLast_reg), .txReady(linkTxReady),
        .rxValid(linkRxValid), .rxIdx(linkRxIdx), .rxData(linkRxData), .rxLast(linkRxLast)
    );
    // ====
    // shared tasks
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        totalChecks++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, got);
            nFail++;
        end
    endtask : chk
    task automatic start(input logic [15:0] m, input logic l, input logic s);
        @(negedge clk_sys);
        arst_n = 1'h0;
        portModeSettingWord = m;
        lead = l;
        slow = s;
        repeat (6) @(negedge clk_sys);
        arst_n = 1'h1;
        // one edge only: the master's first word is taken at the second edge
        @(negedge clk_sys);
    endtask : start
    task automatic wr(input int idx, input logic [15:0] d, input logic expRef);
        @(negedge clk_sys);
        hostWrEn = 1'h1;
        hostWrIdx = 6'(idx);
        hostWrData = d;
        @(negedge clk_sys);
        hostWrEn = 1'h0;
        chk("refused", 16'(expRef), 16'(hostWrRefused_reg));
    endtask : wr
    task automatic rd(input int idx, input logic [15:0] exp);
        @(negedge clk_sys);
        hostRdIdx = 6'(idx);
        @(negedge clk_sys);
        chk("read", exp, hostRdData_reg);
    endtask : rd
    // ====
    // scenarios
    task automatic t_master(input logic [15:0] m, input int half, input logic s);
        start(m, 1'h0, s);
        chk("master", 16'h0001, 16'(isMaster_reg));
        chk("active", 16'h0001, 16'(linkActive_reg));
        chk("first valid", 16'h0001, 16'(linkTxValid_reg));
        chk("first idx", 16'h0000, 16'(linkTxIdx_reg));
        wr(half - 1, 16'h1234, 1'h0);
        wr(half, 16'h5555, 1'h1);
        repeat (700) @(negedge clk_sys);
        chk("mirrored", 16'h1234, u_far_end_model.seen[half - 1]);
        chk("frame end", 16'(2 * half - 1), 16'(u_far_end_model.endIdx));
        rd(half, 16'hA000 | 16'(half));
        rd(2 * half - 1, 16'hA000 | 16'(2 * half - 1));
    endtask : t_master
    task automatic t_slave;
        start(16'h2000, 1'h1, 1'h0);
        chk("slave", 16'h0000, 16'(isMaster_reg));
        chk("active", 16'h0001, 16'(linkActive_reg));
        wr(8, 16'h0BAD, 1'h1);
        repeat (40) @(negedge clk_sys);
        wr(8, 16'hC0DE, 1'h0);
        wr(7, 16'h0BAD, 1'h1);
        wr(16, 16'h0BAD, 1'h1);
        repeat (60) @(negedge clk_sys);
        chk("mirrored", 16'hC0DE, u_far_end_model.seen[8]);
        rd(2, 16'hA002);
    endtask : t_slave
    task automatic t_fault;
        start(16'h5000, 1'h0, 1'h0);
        chk("fault", 16'h0001, 16'(configFault_reg));
        chk("active", 16'h0000, 16'(linkActive_reg));
        wr(0, 16'h0BAD, 1'h1);
    endtask : t_fault
    // ====
    // verdict
    task automatic summarize;
        if (nFail == 0 && totalChecks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : summarize
    initial begin
        #100000;
        nFail++;
        summarize();
    end
    initial begin
        t_master(16'h3200, 8, 1'h0);
        t_master(16'h3100, 16, 1'h1);
        t_master(16'h3000, 32, 1'h0);
        t_slave();
        t_fault();
        summarize();
    end
endmodule : paired_link_area_mirror_tb_top
`default_nettype wire
